// ### console_defs.svh
// Constants for the console track edit control
`ifndef CONSOLE_DEFS_SVH
`define CONSOLE_DEFS_SVH
// ==================================================
// Track geometry and character codes
`define CH_W 6
`define POS_W 7
`define STEP_W 6
`define TRACK_LEN 7'd100
`define LAST_POS 7'd99
`define BLANK_CH 6'h00
`define FILE_TRK 6'h29
`define ACC_TRK 6'h24
`define SYNC_W 3
// ==================================================
// Register map and fields
`define ADDR_W 8
`define A_CTRL 8'h00
`define A_KEY 8'h04
`define A_STAT 8'h08
`define A_IRQS 8'h0c
`define A_IRQE 8'h10
`define A_IRQC 8'h14
`define CTRL_MODE 1:0
`define CTRL_SEL 13:8
`define CTRL_MASK 32'h0000_3f03
`define CTRL_RST 32'h0000_0000
`define KEY_KIND 11:8
`define KEY_CH 5:0
`define ST_STATE 2:0
`define ST_FERR 8
`define ST_RUN 9
`define ST_ARM 10
`define ST_POS 22:16
`define IRQ_W 4
`define IRQ_TYPED 0
`define IRQ_WROTE 1
`define IRQ_FILE 2
`define IRQ_HALT 3
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`endif

// ### console_pkg.sv
// Types shared by the console track edit control
`default_nettype none
package console_pkg;
  typedef enum logic [3:0] {
    K_CHAR = 4'b0000, K_READ = 4'b0001, K_WRITE = 4'b0010, K_EDIT = 4'b0011,
    K_CLEAR = 4'b0100, K_SPACE = 4'b0101, K_START = 4'b0110, K_ERRCLR = 4'b0111,
    K_STEPLOAD = 4'b1000, K_FORMAT = 4'b1001
  } keykind_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_RDSEL = 3'b001, S_WRSEL = 3'b010, S_FILL = 3'b011,
    S_DRUMWR = 3'b100, S_TYPE = 3'b101, S_EDIT = 3'b110
  } state_t;
  typedef enum logic [1:0] {
    M_RUN = 2'b00, M_FMTSTEP = 2'b01, M_SINGLE = 2'b10, M_HALTBEF = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    D_NONE = 2'b00, D_READ = 2'b01, D_WRITE = 2'b10, D_ZERO = 2'b11
  } drumop_t;
  typedef struct packed {
    keykind_t kind;
    logic [5:0] ch;
  } key_t;
  typedef struct packed {
    drumop_t op;
    logic [5:0] track;
  } drum_req_t;
endpackage
`default_nettype wire

// ### key_sync.sv
// Two-stage synchronisers for the console switch pins
`timescale 1ns/1ps
`default_nettype none
`include "console_defs.svh"
module key_sync (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [`SYNC_W-1:0] din,
  output logic [`SYNC_W-1:0] dout
);
  logic [`SYNC_W-1:0] meta;
  genvar i;
  generate
    for (i = 0; i < `SYNC_W; i++) begin : g_bit
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          meta[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          meta[i] <= din[i];
          dout[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### console_track_edit_control.sv
// Console keyboard control: drum track editing, format and program stepping
`timescale 1ns/1ps
`default_nettype none
`include "console_defs.svh"
module console_track_edit_control (
  input wire logic clock,
  input wire logic rstn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irq,
  input wire logic permitLockPin,
  input wire logic diskPlugPin,
  input wire logic copyHeldPin,
  output console_pkg::drum_req_t drumReq,
  output logic drumReqValid,
  input wire logic drumInValid,
  input wire logic [`CH_W-1:0] drumInCh,
  output logic drumOutValid,
  output logic [`CH_W-1:0] drumOutCh,
  output logic typeValid,
  output logic [`CH_W-1:0] typeCh,
  input wire logic typeReady,
  input wire logic typeRequest,
  output logic formatCycle,
  output logic [1:0] formatSel,
  input wire logic stepBoundary,
  input wire logic [`STEP_W-1:0] nextStep,
  input wire logic diskWriteReq,
  output logic diskWriteGrant,
  output logic runEnable,
  output logic stepGo,
  output logic stepLoad,
  output logic [`STEP_W-1:0] stepLoadValue,
  output logic fileError
);
  // ==================================================
  // Pin synchronisation
  logic permitS, plugS, copyS;
  key_sync u_sync (
    .clock(clock),
    .rstn(rstn),
    .din({copyHeldPin, diskPlugPin, permitLockPin}),
    .dout({copyS, plugS, permitS})
  );

  // ==================================================
  // Register bus
  logic awHave, wHave;
  logic [`ADDR_W-1:0] awQ;
  logic [31:0] wdQ;
  logic [3:0] wsQ;
  logic [31:0] ctrlReg;
  logic [`IRQ_W-1:0] irqEn, irqStat;
  console_pkg::state_t state;
  logic [`POS_W-1:0] pos;
  logic fmtArmed;
  wire wrFire = awHave && wHave && !bvalid;
  wire awMapped = awQ == `A_CTRL || awQ == `A_KEY || awQ == `A_STAT ||
    awQ == `A_IRQS || awQ == `A_IRQE || awQ == `A_IRQC;
  wire arMapped = araddr == `A_CTRL || araddr == `A_KEY || araddr == `A_STAT ||
    araddr == `A_IRQS || araddr == `A_IRQE || araddr == `A_IRQC;
  wire [31:0] wmask = {{8{wsQ[3]}}, {8{wsQ[2]}}, {8{wsQ[1]}}, {8{wsQ[0]}}};
  wire [31:0] statWord = {9'h000, pos, 5'h00, fmtArmed, runEnable, fileError,
    5'h00, state};
  wire [31:0] rdMux = araddr == `A_CTRL ? ctrlReg :
    araddr == `A_STAT ? statWord :
    araddr == `A_IRQS ? {28'h0000000, irqStat} :
    araddr == `A_IRQE ? {28'h0000000, irqEn} : 32'h0000_0000;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      awHave <= 1'b0;
      wHave <= 1'b0;
      awQ <= '0;
      wdQ <= '0;
      wsQ <= '0;
      bvalid <= 1'b0;
      bresp <= `RESP_OK;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `RESP_OK;
    end else begin
      awready <= awvalid && !awready && !awHave && !bvalid;
      wready <= wvalid && !wready && !wHave && !bvalid;
      arready <= arvalid && !arready && !rvalid;
      if (awvalid && awready) begin
        awHave <= 1'b1;
        awQ <= awaddr;
      end
      if (wvalid && wready) begin
        wHave <= 1'b1;
        wdQ <= wdata;
        wsQ <= wstrb;
      end
      if (wrFire) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        bvalid <= 1'b1;
        bresp <= awMapped ? `RESP_OK : `RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rdMux;
        rresp <= arMapped ? `RESP_OK : `RESP_ERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ==================================================
  // Key decode
  console_pkg::key_t key;
  assign key = '{kind: console_pkg::keykind_t'(wdQ[`KEY_KIND]), ch: wdQ[`KEY_CH]};
  wire keyEvt = wrFire && awQ == `A_KEY;
  wire isChar = keyEvt && key.kind == console_pkg::K_CHAR;
  wire isSpace = keyEvt && key.kind == console_pkg::K_SPACE;
  wire isClear = keyEvt && key.kind == console_pkg::K_CLEAR;
  wire isStart = keyEvt && key.kind == console_pkg::K_START;
  wire selRead = keyEvt && key.kind == console_pkg::K_READ;
  wire selWrite = keyEvt && key.kind == console_pkg::K_WRITE && permitS;
  wire selEdit = keyEvt && key.kind == console_pkg::K_EDIT && permitS;
  wire canSel = state == console_pkg::S_IDLE || state == console_pkg::S_RDSEL ||
    state == console_pkg::S_WRSEL || state == console_pkg::S_EDIT;
  wire typeFree = !typeValid || typeReady;
  wire atEnd = pos == `TRACK_LEN;
  wire last = pos == `LAST_POS;
  console_pkg::mode_t mode;
  assign mode = console_pkg::mode_t'(ctrlReg[`CTRL_MODE]);
  wire [`STEP_W-1:0] selStep = ctrlReg[`CTRL_SEL];

  // ==================================================
  // Buffer track
  logic [`CH_W-1:0] buffer [0:`TRACK_LEN-1];
  logic fillBlank, clearPend;
  wire fillWe = state == console_pkg::S_FILL && (fillBlank || drumInValid);
  wire editWe = state == console_pkg::S_EDIT && typeFree && !atEnd && (isChar || isSpace);
  wire copyGo = state == console_pkg::S_EDIT && typeFree && !atEnd && copyS && permitS;
  wire [`CH_W-1:0] bufWd = fillWe ? (fillBlank ? `BLANK_CH : drumInCh) :
    (isSpace ? `BLANK_CH : key.ch);
  wire [`CH_W-1:0] bufRd = buffer[atEnd ? `LAST_POS : pos];

  always_ff @(posedge clock) begin
    if (fillWe || editWe) begin
      buffer[pos] <= bufWd;
    end
  end

  // ==================================================
  // Edit sequence
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= console_pkg::S_IDLE;
      pos <= '0;
      fillBlank <= 1'b0;
      clearPend <= 1'b0;
      drumReq <= '0;
      drumReqValid <= 1'b0;
      drumOutValid <= 1'b0;
      drumOutCh <= '0;
      typeValid <= 1'b0;
      typeCh <= '0;
    end else begin
      drumReqValid <= 1'b0;
      drumOutValid <= 1'b0;
      if (typeValid && typeReady) begin
        typeValid <= 1'b0;
      end
      if (isClear && state == console_pkg::S_DRUMWR) begin
        clearPend <= 1'b1;
      end
      if (isClear && state != console_pkg::S_DRUMWR) begin
        state <= console_pkg::S_IDLE;
        pos <= '0;
        typeValid <= 1'b0;
      end else if (canSel && (selRead || selWrite || selEdit)) begin
        pos <= '0;
        state <= selRead ? console_pkg::S_RDSEL :
          selWrite ? console_pkg::S_WRSEL : console_pkg::S_EDIT;
      end else begin
        unique case (state)
          console_pkg::S_IDLE: begin
          end
          console_pkg::S_RDSEL: begin
            if (isChar && key.ch == `ACC_TRK) begin
              if (permitS) begin
                drumReq <= '{op: console_pkg::D_ZERO, track: key.ch};
                drumReqValid <= 1'b1;
                state <= console_pkg::S_IDLE;
              end
            end else if (isChar) begin
              drumReq <= '{op: console_pkg::D_READ, track: key.ch};
              drumReqValid <= 1'b1;
              fillBlank <= 1'b0;
              state <= console_pkg::S_FILL;
            end else if (isSpace) begin
              fillBlank <= 1'b1;
              state <= console_pkg::S_FILL;
            end
          end
          console_pkg::S_WRSEL: begin
            if (isChar && key.ch != `FILE_TRK) begin
              drumReq <= '{op: console_pkg::D_WRITE, track: key.ch};
              drumReqValid <= 1'b1;
              state <= console_pkg::S_DRUMWR;
            end
          end
          console_pkg::S_FILL: begin
            if (fillWe) begin
              pos <= last ? '0 : pos + 1'b1;
              if (last) begin
                state <= fillBlank ? console_pkg::S_IDLE : console_pkg::S_TYPE;
              end
            end
          end
          console_pkg::S_DRUMWR: begin
            drumOutValid <= 1'b1;
            drumOutCh <= bufRd;
            pos <= last ? '0 : pos + 1'b1;
            if (last) begin
              clearPend <= 1'b0;
              state <= clearPend || isClear ? console_pkg::S_IDLE : console_pkg::S_TYPE;
            end
          end
          console_pkg::S_TYPE: begin
            if (typeFree && atEnd) begin
              state <= console_pkg::S_IDLE;
              pos <= '0;
            end else if (typeFree) begin
              typeValid <= 1'b1;
              typeCh <= bufRd;
              pos <= pos + 1'b1;
            end
          end
          console_pkg::S_EDIT: begin
            if (editWe) begin
              typeValid <= 1'b1;
              typeCh <= bufWd;
              pos <= pos + 1'b1;
            end else if (copyGo) begin
              typeValid <= 1'b1;
              typeCh <= bufRd;
              pos <= pos + 1'b1;
            end
          end
          default: begin
            state <= console_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // ==================================================
  // Format and program stepping
  wire haltHit = stepBoundary && mode == console_pkg::M_HALTBEF &&
    nextStep == selStep && runEnable;
  wire diskBlock = diskWriteReq && !plugS;
  wire fmtKey = keyEvt && key.kind == console_pkg::K_FORMAT && key.ch[1:0] != 2'b00;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      runEnable <= 1'b0;
      stepGo <= 1'b0;
      formatCycle <= 1'b0;
      formatSel <= 2'b00;
      fmtArmed <= 1'b0;
      diskWriteGrant <= 1'b0;
      fileError <= 1'b0;
      stepLoad <= 1'b0;
      stepLoadValue <= '0;
    end else begin
      stepGo <= 1'b0;
      stepLoad <= 1'b0;
      diskWriteGrant <= diskWriteReq && plugS;
      formatCycle <= mode != console_pkg::M_FMTSTEP && fmtArmed;
      if (isClear) begin
        fmtArmed <= 1'b0;
      end
      if (fmtKey || typeRequest) begin
        fmtArmed <= 1'b1;
        formatSel <= fmtKey ? key.ch[1:0] : 2'b00;
      end
      if (isStart && !fileError) begin
        unique case (mode)
          console_pkg::M_FMTSTEP: formatCycle <= fmtArmed;
          console_pkg::M_SINGLE: begin
            stepGo <= 1'b1;
            runEnable <= 1'b0;
          end
          console_pkg::M_RUN, console_pkg::M_HALTBEF: runEnable <= 1'b1;
        endcase
      end
      if (haltHit) begin
        runEnable <= 1'b0;
      end
      if (keyEvt && key.kind == console_pkg::K_STEPLOAD) begin
        stepLoad <= 1'b1;
        stepLoadValue <= selStep;
      end
      if (keyEvt && key.kind == console_pkg::K_ERRCLR) begin
        fileError <= 1'b0;
      end
      if (diskBlock) begin
        fileError <= 1'b1;
        runEnable <= 1'b0;
      end
    end
  end

  // ==================================================
  // Control registers and interrupts
  wire [`IRQ_W-1:0] irqEvt = {haltHit, diskBlock,
    state == console_pkg::S_DRUMWR && last,
    state == console_pkg::S_TYPE && typeFree && atEnd};
  wire [`IRQ_W-1:0] irqClr = wrFire && awQ == `A_IRQC ? wdQ[`IRQ_W-1:0] & wmask[`IRQ_W-1:0]
    : '0;
  wire [`IRQ_W-1:0] next_irqStat = (irqStat & ~irqClr) | irqEvt;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrlReg <= `CTRL_RST;
      irqEn <= '0;
      irqStat <= '0;
      irq <= 1'b0;
    end else begin
      if (wrFire && awQ == `A_CTRL) begin
        ctrlReg <= ((ctrlReg & ~wmask) | (wdQ & wmask)) & `CTRL_MASK;
      end
      if (wrFire && awQ == `A_IRQE) begin
        irqEn <= (irqEn & ~wmask[`IRQ_W-1:0]) | (wdQ[`IRQ_W-1:0] & wmask[`IRQ_W-1:0]);
      end
      irqStat <= next_irqStat;
      irq <= |(next_irqStat & irqEn);
    end
  end

  // ==================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_edit_permit;
    isClear == 1'b0 && keyEvt && key.kind == console_pkg::K_EDIT && !permitS &&
      state != console_pkg::S_EDIT |=> state != console_pkg::S_EDIT;
  endproperty
  a_edit_permit: assert property (p_edit_permit) else $error("edit entered unlocked");
  property p_read_track;
    state == console_pkg::S_RDSEL && isChar && key.ch != `ACC_TRK |=>
      drumReqValid && drumReq.op == console_pkg::D_READ && state == console_pkg::S_FILL;
  endproperty
  a_read_track: assert property (p_read_track) else $error("read not started");
  property p_write_burst;
    state == console_pkg::S_WRSEL && isChar && key.ch != `FILE_TRK |=>
      state == console_pkg::S_DRUMWR ##1 drumOutValid ##99
      (drumOutValid && state != console_pkg::S_DRUMWR);
  endproperty
  a_write_burst: assert property (p_write_burst) else $error("write burst wrong");
  property p_file_guard;
    state == console_pkg::S_WRSEL && isChar && key.ch == `FILE_TRK |=>
      !drumReqValid && state == console_pkg::S_WRSEL;
  endproperty
  a_file_guard: assert property (p_file_guard) else $error("file track written");
  property p_clear_stop;
    isClear && state == console_pkg::S_TYPE |=> state == console_pkg::S_IDLE && !typeValid;
  endproperty
  a_clear_stop: assert property (p_clear_stop) else $error("clear did not stop");
  property p_blank_fill;
    state == console_pkg::S_RDSEL && isSpace |=> state == console_pkg::S_FILL ##100
      state == console_pkg::S_IDLE;
  endproperty
  a_blank_fill: assert property (p_blank_fill) else $error("blank fill length");
  property p_acc_zero;
    state == console_pkg::S_RDSEL && isChar && key.ch == `ACC_TRK && permitS |=>
      drumReqValid && drumReq.op == console_pkg::D_ZERO;
  endproperty
  a_acc_zero: assert property (p_acc_zero) else $error("accumulator not reset");
  property p_fmt_step;
    isStart && !fileError && fmtArmed && mode == console_pkg::M_FMTSTEP &&
      $stable(mode) |=> formatCycle ##1 !formatCycle;
  endproperty
  a_fmt_step: assert property (p_fmt_step) else $error("format step not single");
  property p_single;
    isStart && !fileError && mode == console_pkg::M_SINGLE |=> stepGo && !runEnable;
  endproperty
  a_single: assert property (p_single) else $error("single step wrong");
  property p_halt_before;
    haltHit && !isStart |=> !runEnable;
  endproperty
  a_halt_before: assert property (p_halt_before) else $error("no halt before step");
  property p_disk_guard;
    diskWriteReq && !plugS |=> fileError && !diskWriteGrant && !runEnable;
  endproperty
  a_disk_guard: assert property (p_disk_guard) else $error("guarded write passed");
  c_write: cover property (state == console_pkg::S_DRUMWR ##1 state == console_pkg::S_TYPE);
  c_copy: cover property (copyGo);
  c_halt: cover property (haltHit);
endmodule
`default_nettype wire

// ### console_far_model.sv
// Far-side model: drum track reader and a pacing typewriter
`timescale 1ns/1ps
`default_nettype none
module console_far_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic slow,
  input wire console_pkg::drum_req_t drumReq,
  input wire logic drumReqValid,
  input wire logic typeValid,
  output logic typeReady,
  output logic drumInValid,
  output logic [5:0] drumInCh
);
  logic [6:0] left;
  logic [5:0] pos;
  logic [5:0] trk;
  logic [1:0] pace;
  // Slow typewriter takes one char in four cycles
  assign typeReady = typeValid && (!slow || pace == 2'h3);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {left, pos, trk, pace, drumInValid, drumInCh} <= 28'h0;
    end else begin
      pace <= pace + 2'h1;
      drumInValid <= left != 7'h0;
      // Idle data line keeps flipping
      drumInCh <= (left != 7'h0) ? pos ^ trk : ~drumInCh;
      if (left != 7'h0) begin
        left <= left - 7'h1;
        pos <= pos + 6'h1;
      end
      if (drumReqValid && drumReq.op == console_pkg::D_READ) begin
        {left, pos, trk} <= {7'h64, 6'h0, drumReq.track};
      end
    end
  end
endmodule
`default_nettype wire

// ### console_track_edit_control_tb.sv
// Self-checking testbench for the console track edit control
`timescale 1ns/1ps
`default_nettype none
`include "console_defs.svh"
module console_track_edit_control_tb;
  logic clock, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, irq, permitLockPin, diskPlugPin, copyHeldPin, drumReqValid;
  logic drumInValid, drumOutValid, typeValid, typeReady, typeRequest, formatCycle;
  logic stepBoundary, diskWriteReq, diskWriteGrant, runEnable, stepGo, stepLoad;
  logic fileError, slow;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, formatSel, resp;
  logic [5:0] drumInCh, drumOutCh, typeCh, nextStep, stepLoadValue, trk, loadVal;
  console_pkg::drum_req_t drumReq, lastReq;
  logic [5:0] outBuf [0:255];
  logic [5:0] typBuf [0:255];
  int failures, total_checks, nReq, nOut, nTyp, nGo, nFmt, nGrant, nLoad, i, k, j;

  console_track_edit_control i_dut (.clock, .rstn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .irq, .permitLockPin, .diskPlugPin, .copyHeldPin, .drumReq,
    .drumReqValid, .drumInValid, .drumInCh, .drumOutValid, .drumOutCh, .typeValid, .typeCh,
    .typeReady, .typeRequest, .formatCycle, .formatSel, .stepBoundary, .nextStep,
    .diskWriteReq, .diskWriteGrant, .runEnable, .stepGo, .stepLoad, .stepLoadValue,
    .fileError);
  console_far_model i_far (.clock, .rstn, .slow, .drumReq, .drumReqValid, .typeValid,
    .typeReady, .drumInValid, .drumInCh);

  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end

  // ==========
  // Monitors
  always @(posedge clock) begin
    if (drumReqValid) begin
      nReq++;
      lastReq = drumReq;
    end
    if (drumOutValid) begin
      outBuf[nOut % 256] = drumOutCh;
      nOut++;
    end
    if (typeValid && typeReady) begin
      typBuf[nTyp % 256] = typeCh;
      nTyp++;
    end
    nGo += int'(stepGo);
    nFmt += int'(formatCycle);
    nGrant += int'(diskWriteGrant);
    if (stepLoad) begin
      nLoad++;
      loadVal = stepLoadValue;
    end
  end

  // ==========
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'b111;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1 && n < 100);
    resp = bresp;
    bready <= 0;
    @(posedge clock);
    chk(n < 100, 1);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    int n;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1 && n < 100);
    {resp, d} = {rresp, rdata};
    rready <= 0;
    @(posedge clock);
    chk(n < 100, 1);
  endtask
  task automatic key(input console_pkg::keykind_t kk, input logic [5:0] c);
    axw(`A_KEY, {20'h0, kk, 2'b0, c}, 4'hf);
  endtask
  task automatic hit(input logic [2:0] m);
    {typeRequest, stepBoundary, diskWriteReq} <= m;
    @(posedge clock);
    {typeRequest, stepBoundary, diskWriteReq} <= 3'b0;
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clock);
    failures++;
    final_report;
  end

  // ==========
  // Scenarios
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, permitLockPin, diskPlugPin, copyHeldPin} = 0;
    {typeRequest, stepBoundary, diskWriteReq, slow, rstn} = 0;
    {awaddr, araddr, wdata, wstrb, nextStep} = 0;
    rnd = 32'hbdca;
    repeat (8) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    axr(`A_CTRL, rd);
    chk(rd, `CTRL_RST);
    axw(`A_CTRL, 32'hffffffff, 4'h1);
    chk(resp, `RESP_OK);
    axr(`A_CTRL, rd);
    chk(rd, 32'h3);
    axw(`A_CTRL, 32'hffffffff, 4'hf);
    axr(`A_CTRL, rd);
    chk(rd, `CTRL_MASK);
    axw(`A_CTRL, 32'h0, 4'hf);
    axr(8'h40, rd);
    chk(resp, `RESP_ERR);
    chk(rd, 32'h0);
    axw(8'h40, 32'h1, 4'hf);
    chk(resp, `RESP_ERR);
    key(console_pkg::K_EDIT, 6'h0);
    axr(`A_STAT, rd);
    chk(rd[2:0], console_pkg::S_IDLE);
    copyHeldPin <= 1;
    k = nTyp;
    cyc(20);
    chk(nTyp - k, 0);
    copyHeldPin <= 0;
    // Random track read, typed out whole
    rnd = lfsr(lfsr(rnd));
    trk = {1'b0, rnd[4:0]};
    slow <= rnd[7];
    key(console_pkg::K_READ, 6'h0);
    k = nTyp;
    key(console_pkg::K_CHAR, trk);
    for (i = 0; i < 3000 && nTyp - k < 100; i++) @(posedge clock);
    chk(lastReq, {console_pkg::D_READ, trk});
    for (i = 0; i < 100; i++) chk(typBuf[(k + i) % 256], 6'(i) ^ trk);
    chk(irq, 0);
    axw(`A_IRQE, 32'h1, 4'hf);
    cyc(2);
    chk(irq, 1);
    axw(`A_IRQC, 32'hf, 4'hf);
    cyc(2);
    chk(irq, 0);
    // Edit one char, then write through the buffer
    permitLockPin <= 1;
    slow <= 1;
    cyc(4);
    key(console_pkg::K_EDIT, 6'h0);
    k = nTyp;
    key(console_pkg::K_CHAR, rnd[13:8]);
    cyc(8);
    chk(typBuf[k % 256], rnd[13:8]);
    copyHeldPin <= 1;
    cyc(12);
    copyHeldPin <= 0;
    cyc(8);
    chk(typBuf[(k + 1) % 256], trk ^ 6'h1);
    key(console_pkg::K_CLEAR, 6'h0);
    key(console_pkg::K_WRITE, 6'h0);
    j = nReq;
    key(console_pkg::K_CHAR, `FILE_TRK);
    cyc(4);
    chk(nReq - j, 0);
    j = nTyp;
    k = nOut;
    key(console_pkg::K_CHAR, 6'h07);
    for (i = 0; i < 300 && nOut - k < 100; i++) @(posedge clock);
    chk(lastReq, {console_pkg::D_WRITE, 6'h07});
    chk(nTyp - j < 10, 1);
    chk(outBuf[k % 256], rnd[13:8]);
    chk(outBuf[(k + 1) % 256], trk ^ 6'h1);
    key(console_pkg::K_CLEAR, 6'h0);
    cyc(8);
    j = nTyp;
    cyc(30);
    chk(nTyp - j, 0);
    // Blank buffer, then blank a track
    key(console_pkg::K_READ, 6'h0);
    key(console_pkg::K_SPACE, 6'h0);
    cyc(110);
    key(console_pkg::K_CLEAR, 6'h0);
    key(console_pkg::K_WRITE, 6'h0);
    k = nOut;
    key(console_pkg::K_CHAR, 6'h0a);
    for (i = 0; i < 300 && nOut - k < 100; i++) @(posedge clock);
    rd = 0;
    for (i = 0; i < 100; i++) rd |= 32'(outBuf[(k + i) % 256] ^ `BLANK_CH);
    chk(nOut - k, 100);
    chk(rd, 32'h0);
    key(console_pkg::K_CLEAR, 6'h0);
    key(console_pkg::K_READ, 6'h0);
    key(console_pkg::K_CHAR, `ACC_TRK);
    cyc(2);
    chk(lastReq, {console_pkg::D_ZERO, `ACC_TRK});
    permitLockPin <= 0;
    // Format programs and stepping
    for (i = 1; i < 4; i++) begin
      key(console_pkg::K_FORMAT, 6'(i));
      cyc(2);
      chk(formatSel, i);
    end
    hit(3'b100);
    cyc(2);
    chk(formatSel, 0);
    axw(`A_CTRL, 32'h1, 4'hf);
    k = nFmt;
    cyc(4);
    chk(nFmt - k, 0);
    key(console_pkg::K_START, 6'h0);
    cyc(3);
    chk(nFmt - k, 1);
    axw(`A_CTRL, 32'h2, 4'hf);
    k = nGo;
    key(console_pkg::K_START, 6'h0);
    cyc(3);
    chk(nGo - k, 1);
    axw(`A_CTRL, 32'h0503, 4'hf);
    key(console_pkg::K_START, 6'h0);
    nextStep <= 6'h04;
    hit(3'b010);
    cyc(2);
    chk(runEnable, 1);
    nextStep <= 6'h05;
    hit(3'b010);
    cyc(2);
    chk(runEnable, 0);
    // Guarded disk write and resume
    axw(`A_CTRL, 32'h0600, 4'hf);
    key(console_pkg::K_START, 6'h0);
    diskPlugPin <= 1;
    cyc(4);
    k = nGrant;
    hit(3'b001);
    cyc(2);
    chk(nGrant - k, 1);
    diskPlugPin <= 0;
    cyc(4);
    hit(3'b001);
    cyc(2);
    chk(nGrant - k, 1);
    chk({fileError, runEnable}, 2'b10);
    key(console_pkg::K_ERRCLR, 6'h0);
    chk(fileError, 0);
    axw(`A_CTRL, 32'h0700, 4'hf);
    k = nLoad;
    key(console_pkg::K_STEPLOAD, 6'h0);
    cyc(2);
    chk(nLoad - k, 1);
    chk(loadVal, 6'h07);
    key(console_pkg::K_START, 6'h0);
    cyc(2);
    chk(runEnable, 1);
    axr(`A_IRQS, rd);
    chk(rd[3:2], 2'b11);
    final_report;
  end
endmodule
`default_nettype wire
